// file: logic/lsab_pkg.sv
// package of constants for the loop status and alarm bit bank
package lsab_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned LSAB_UNITS = 32;      // field units on the loop
  localparam int unsigned LSAB_SOURCES = 4;     // accept sources: serial, network, display
  localparam int unsigned LSAB_STATIONS = 4;    // logical stations per physical station
  localparam int unsigned LSAB_ALARMS = 5;      // latched alarm bits per view
  // ----------------------------------------
  // alarm bit positions in each view
  // ----------------------------------------
  localparam int unsigned LSAB_AL_AUTO_LOOPBACK = 0;
  localparam int unsigned LSAB_AL_ACTUATOR = 1;
  localparam int unsigned LSAB_AL_UNIT = 2;
  localparam int unsigned LSAB_AL_LOOP_BUSY = 3;
  localparam int unsigned LSAB_AL_POWER_ON = 4;
  // ----------------------------------------
  // desired-position write frame
  // ----------------------------------------
  localparam logic [7:0] LSAB_FUNC_WRITE_REG = 8'h06;   // single holding register write
  localparam logic [15:0] LSAB_ADDR_OFFSET = 16'h0001;  // frame address is location minus one
  localparam logic [22:0] LSAB_FULL_SCALE = 23'h007ffe; // first variant full scale
  localparam logic [22:0] LSAB_PCT_DIV = 23'h000064;    // hundred percent
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [LSAB_ALARMS-1:0] LSAB_ALARM_RST = 5'h00;
  localparam logic [7:0] LSAB_STATION_RST = 8'h01;      // base station address default
  // ----------------------------------------
  // position encoder states
  // ----------------------------------------
  typedef enum logic [0:0] {
    LSAB_POS_IDLE = 1'b0,
    LSAB_POS_DONE = 1'b1
  } lsab_pos_state_type;
endpackage

// file: logic/lsab_bank.sv
// loop status and alarm bit bank with per-source alarm views
//
// What this block does
// - position write: function 06, address = location-1
// - half open encodes 3fff or 0032 by variant
// - four logical stations, identical status data
// - write at any station applies to all
// - present condition reads one, absent zero
// - set auto-loopback alarm on loop reconfiguration
// - actuator alarm ORs all unavailable flags
// - unit alarm on any alarm or comms loss
// - shutdown mode: contact open and option enabled
// - loopback-in-progress held during loop reconfiguration
// - loopback in use blocks loop doubling
// - power-on alarm after power lost, restored
// - alarm clears after read, accept, source normal
// - side bit zero for A, one B
// - separate health bits for sides A, B
// - ownership bit one when answering side primary
// - loop owner input picks primary side; standby bits only when paired
// - one accept coil, separate per-source views
module lsab_bank
  import lsab_pkg::*;
#(
  parameter int unsigned UNITS = lsab_pkg::LSAB_UNITS,
  parameter int unsigned SOURCES = lsab_pkg::LSAB_SOURCES,
  parameter logic [7:0] STATION_ADDR0 = lsab_pkg::LSAB_STATION_RST,
  parameter logic [7:0] STATION_ADDR1 = 8'h02,
  parameter logic [7:0] STATION_ADDR2 = 8'h03,
  parameter logic [7:0] STATION_ADDR3 = 8'h04
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // loop management inputs, same clock
  input wire logic loop_reconfig_event,
  input wire logic loop_reconfig_busy,
  input wire logic loopback_active,
  input wire logic loop_doubling_request,
  input wire logic power_restored_event,
  input wire logic [UNITS-1:0] actuator_unavailable_flag,
  input wire logic [UNITS-1:0] field_unit_alarm,
  input wire logic [UNITS-1:0] field_unit_comm_fail,
  // shutdown contact pin, high when closed
  input wire logic emergency_shutdown_input,
  input wire logic remote_shutdown_enable,
  // standby pair inputs
  input wire logic standby_pair_config,
  input wire logic answering_side_b,
  input wire logic side_a_healthy,
  input wire logic side_b_healthy,
  input wire logic loop_owner_side_b,
  // per accept source requests
  input wire logic [SOURCES*8-1:0] source_slave_addr,
  input wire logic [SOURCES-1:0] source_status_read,
  input wire logic [SOURCES-1:0] source_alarm_accept,
  // desired-position write request
  input wire logic pos_request,
  input wire logic [7:0] pos_unit,
  input wire logic [6:0] pos_percent,
  input wire logic pos_variant_pct,
  // status outputs
  output logic [SOURCES*lsab_pkg::LSAB_ALARMS-1:0] alarm_view,
  output logic [SOURCES-1:0] source_addr_hit,
  output logic emergency_shutdown_mode,
  output logic loopback_in_progress,
  output logic loopback_in_use,
  output logic loop_doubling_available,
  output logic side_indicator,
  output logic side_a_ok,
  output logic side_b_ok,
  output logic control_owner,
  output logic [7:0] pos_func,
  output logic [15:0] pos_addr,
  output logic [15:0] pos_data,
  output logic pos_valid
);
  import lsab_pkg::*;

  // ----------------------------------------
  // shutdown contact synchroniser
  // ----------------------------------------
  logic shut_meta_q;  // first stage, read only by second stage
  logic shut_sync_q;  // second stage, safe to use

  // two flops since the contact comes straight from a terminal
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shut_meta_q <= 1'b1;
      shut_sync_q <= 1'b1;
    end
    else if (clk_en)
    begin
      shut_meta_q <= emergency_shutdown_input;
      shut_sync_q <= shut_meta_q;
    end
  end

  // ----------------------------------------
  // alarm sources and plain status
  // ----------------------------------------
  logic [LSAB_ALARMS-1:0] src_active;  // source presently abnormal or event now
  logic [SOURCES-1:0] accept_ok;       // accept that reached a known station
  logic shut_d, shut_q, lip_d, lip_q, liu_d, liu_q, dbl_d, dbl_q;
  logic side_d, side_q, aok_d, aok_q, bok_d, bok_q, own_d, own_q;

  // every status bit is one when its condition is present
  always_comb
  begin
    src_active = '0;
    src_active[LSAB_AL_AUTO_LOOPBACK] = loop_reconfig_event;
    src_active[LSAB_AL_ACTUATOR] = |actuator_unavailable_flag;
    src_active[LSAB_AL_UNIT] = |(field_unit_alarm | field_unit_comm_fail);
    src_active[LSAB_AL_LOOP_BUSY] = loop_reconfig_busy;
    src_active[LSAB_AL_POWER_ON] = power_restored_event;
    shut_d = !shut_sync_q && remote_shutdown_enable;
    lip_d = loop_reconfig_busy;
    liu_d = loopback_active;
    dbl_d = loop_doubling_request && !loopback_active;
    // standby bits read zero unless configured as a pair
    side_d = standby_pair_config && answering_side_b;
    aok_d = standby_pair_config && side_a_healthy;
    bok_d = standby_pair_config && side_b_healthy;
    own_d = standby_pair_config && (answering_side_b == loop_owner_side_b);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shut_q <= 1'b0;
      lip_q <= 1'b0;
      liu_q <= 1'b0;
      dbl_q <= 1'b0;
      side_q <= 1'b0;
      aok_q <= 1'b0;
      bok_q <= 1'b0;
      own_q <= 1'b0;
    end
    else if (clk_en)
    begin
      shut_q <= shut_d;
      lip_q <= lip_d;
      liu_q <= liu_d;
      dbl_q <= dbl_d;
      side_q <= side_d;
      aok_q <= aok_d;
      bok_q <= bok_d;
      own_q <= own_d;
    end
  end

  assign emergency_shutdown_mode = shut_q;
  assign loopback_in_progress = lip_q;
  assign loopback_in_use = liu_q;
  assign loop_doubling_available = dbl_q;
  assign side_indicator = side_q;
  assign side_a_ok = aok_q;
  assign side_b_ok = bok_q;
  assign control_owner = own_q;

  // ----------------------------------------
  // per-source latched alarm views
  // ----------------------------------------
  logic [LSAB_ALARMS-1:0] latch_q [SOURCES];  // latched alarm per view
  logic [LSAB_ALARMS-1:0] latch_d [SOURCES];
  logic [LSAB_ALARMS-1:0] seen_q [SOURCES];   // host has read it since set
  logic [LSAB_ALARMS-1:0] seen_d [SOURCES];

  genvar s;
  generate
    for (s = 0; s < SOURCES; s++)
    begin : g_src
      logic [7:0] addr;
      assign addr = source_slave_addr[s*8 +: 8];
      // any logical station address is the same bank, so one hit serves all
      assign source_addr_hit[s] = (addr == STATION_ADDR0) || (addr == STATION_ADDR1)
        || (addr == STATION_ADDR2) || (addr == STATION_ADDR3);
      assign accept_ok[s] = source_alarm_accept[s] && source_addr_hit[s];

      // set beats clear: an active source keeps the bit latched
      always_comb
      begin
        seen_d[s] = seen_q[s];
        if (source_status_read[s] && source_addr_hit[s])
        begin
          seen_d[s] = seen_q[s] | latch_q[s];
        end
        // drop only where read, accepted and back to normal
        latch_d[s] = latch_q[s] | src_active;
        if (accept_ok[s])
        begin
          latch_d[s] = (latch_q[s] & ~(seen_q[s] & ~src_active)) | src_active;
        end
        seen_d[s] = seen_d[s] & latch_d[s];
      end

      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          latch_q[s] <= LSAB_ALARM_RST;
          seen_q[s] <= LSAB_ALARM_RST;
        end
        else if (clk_en)
        begin
          latch_q[s] <= latch_d[s];
          seen_q[s] <= seen_d[s];
        end
      end
      assign alarm_view[s*LSAB_ALARMS +: LSAB_ALARMS] = latch_q[s];

      a_clear_needs_cause: assert property (@(posedge clk) disable iff (reset)
        clk_en && $past(clk_en) && $fell(latch_q[s][LSAB_AL_UNIT])
          |-> $past(accept_ok[s]) && $past(seen_q[s][LSAB_AL_UNIT]))
        else $error("alarm dropped without read and accept");
      a_clear_next_cycle: assert property (@(posedge clk) disable iff (reset)
        clk_en && accept_ok[s] && seen_q[s][LSAB_AL_POWER_ON] && !power_restored_event
          ##1 clk_en |-> !latch_q[s][LSAB_AL_POWER_ON])
        else $error("accepted alarm did not drop next cycle");
      a_event_latches: assert property (@(posedge clk) disable iff (reset)
        clk_en && loop_reconfig_event ##1 clk_en [*3]
          |-> latch_q[s][LSAB_AL_AUTO_LOOPBACK] || $past(accept_ok[s]))
        else $error("auto loopback event not latched");
    end
  endgenerate

  // ----------------------------------------
  // desired-position write encoder
  // ----------------------------------------
  lsab_pos_state_type pos_st_q, pos_st_d;
  logic [7:0] func_q, func_d;
  logic [15:0] addr_q, addr_d, data_q, data_d;
  logic [22:0] scaled;  // percent times full scale

  // two variants: scaled binary or raw percent
  always_comb
  begin
    scaled = 23'({16'h0000, pos_percent}) * LSAB_FULL_SCALE;
    pos_st_d = LSAB_POS_IDLE;
    func_d = func_q;
    addr_d = addr_q;
    data_d = data_q;
    case (pos_st_q)
      LSAB_POS_IDLE, LSAB_POS_DONE:
      begin
        if (pos_request)
        begin
          pos_st_d = LSAB_POS_DONE;
          func_d = LSAB_FUNC_WRITE_REG;
          addr_d = {8'h00, pos_unit} - LSAB_ADDR_OFFSET;
          if (pos_variant_pct)
          begin
            data_d = {9'h000, pos_percent};
          end
          else
          begin
            data_d = 16'(scaled / LSAB_PCT_DIV);
          end
        end
      end
      default:
      begin
        pos_st_d = LSAB_POS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pos_st_q <= LSAB_POS_IDLE;
      func_q <= 8'h00;
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      pos_st_q <= pos_st_d;
      func_q <= func_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign pos_func = func_q;
  assign pos_addr = addr_q;
  assign pos_data = data_q;
  assign pos_valid = (pos_st_q == LSAB_POS_DONE);

  // ----------------------------------------
  // checks on status and encoder
  // ----------------------------------------
  a_shut_mode_cause: assert property (@(posedge clk) disable iff (reset)
    $past(clk_en) && emergency_shutdown_mode |-> $past(remote_shutdown_enable, 1))
    else $error("shutdown mode without option enabled");
  a_doubling_blocked: assert property (@(posedge clk) disable iff (reset)
    loopback_in_use |-> !loop_doubling_available)
    else $error("loop doubling offered while loopback in use");
  a_standby_gated: assert property (@(posedge clk) disable iff (reset)
    clk_en && !standby_pair_config ##1 clk_en
      |-> !(side_indicator || side_a_ok || side_b_ok || control_owner))
    else $error("standby bit set without pair config");
  a_busy_follows: assert property (@(posedge clk) disable iff (reset)
    clk_en && loop_reconfig_busy ##1 clk_en |-> loopback_in_progress)
    else $error("busy not shown during reconfiguration");
  a_pos_half_open: assert property (@(posedge clk) disable iff (reset)
    clk_en && pos_request && pos_percent == 7'h32 && pos_unit == 8'h1a
      ##1 clk_en |-> pos_valid && pos_addr == 16'h0019 && pos_func == 8'h06
        && pos_data == ($past(pos_variant_pct) ? 16'h0032 : 16'h3fff))
    else $error("half-open write frame wrong");
  a_owner_side: assert property (@(posedge clk) disable iff (reset)
    clk_en && standby_pair_config && answering_side_b != loop_owner_side_b
      ##1 clk_en |-> !control_owner)
    else $error("standby side reported as owner");
endmodule

// file: test/lsab_host_model.sv
// host master model that issues status reads and alarm accepts
module lsab_host_model
#(
  parameter int unsigned SOURCES = lsab_pkg::LSAB_SOURCES
)
(
  input wire logic clk,
  output logic [SOURCES*8-1:0] source_slave_addr,
  output logic [SOURCES-1:0] source_status_read,
  output logic [SOURCES-1:0] source_alarm_accept
);
  timeunit 1ns;
  timeprecision 1ns;
  import lsab_pkg::*;
  // ----------------------------------------
  // host side of the accept sources
  // ----------------------------------------
  // every source talks to the base station unless moved on purpose
  initial
  begin
    source_slave_addr = {SOURCES{LSAB_STATION_RST}};
    source_status_read = '0;
    source_alarm_accept = '0;
  end
  // one-cycle read or accept, launched and dropped at falling edges
  task automatic pulse(input int s, input logic acc);
    @(negedge clk);
    if (acc)
      source_alarm_accept[s] = 1'b1;
    else
      source_status_read[s] = 1'b1;
    @(negedge clk);
    source_alarm_accept[s] = 1'b0;
    source_status_read[s] = 1'b0;
  endtask
  // move one source to another slave address
  task automatic set_addr(input int s, input logic [7:0] a);
    source_slave_addr[s*8+:8] = a;
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench for the loop status and alarm bit bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lsab_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
  logic loop_reconfig_event = 1'b0, loop_reconfig_busy = 1'b0, loopback_active = 1'b0;
  logic loop_doubling_request = 1'b0, power_restored_event = 1'b0;
  logic [31:0] actuator_unavailable_flag = '0, field_unit_alarm = '0, field_unit_comm_fail = '0;
  logic emergency_shutdown_input = 1'b1, remote_shutdown_enable = 1'b0;
  logic standby_pair_config = 1'b0, answering_side_b = 1'b0, loop_owner_side_b = 1'b0;
  logic side_a_healthy = 1'b0, side_b_healthy = 1'b0;
  logic pos_request = 1'b0, pos_variant_pct = 1'b0;
  logic [7:0] pos_unit = 8'h1a;
  logic [6:0] pos_percent = 7'h32;
  logic [31:0] source_slave_addr;
  logic [3:0] source_status_read, source_alarm_accept, source_addr_hit;
  logic [19:0] alarm_view;
  logic emergency_shutdown_mode, loopback_in_progress, loopback_in_use, loop_doubling_available;
  logic side_indicator, side_a_ok, side_b_ok, control_owner, pos_valid;
  logic [7:0] pos_func;
  logic [15:0] pos_addr, pos_data;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // ----------------------------------------
  // block under test and host model
  // ----------------------------------------
  lsab_bank i_lsab_bank (.clk, .reset, .clk_en, .loop_reconfig_event, .loop_reconfig_busy,
    .loopback_active, .loop_doubling_request, .power_restored_event,
    .actuator_unavailable_flag, .field_unit_alarm, .field_unit_comm_fail,
    .emergency_shutdown_input, .remote_shutdown_enable, .standby_pair_config,
    .answering_side_b, .side_a_healthy, .side_b_healthy, .loop_owner_side_b,
    .source_slave_addr, .source_status_read, .source_alarm_accept, .pos_request, .pos_unit,
    .pos_percent, .pos_variant_pct, .alarm_view, .source_addr_hit, .emergency_shutdown_mode,
    .loopback_in_progress, .loopback_in_use, .loop_doubling_available, .side_indicator,
    .side_a_ok, .side_b_ok, .control_owner, .pos_func, .pos_addr, .pos_data, .pos_valid);
  lsab_host_model i_lsab_host_model (.clk, .source_slave_addr, .source_status_read,
    .source_alarm_accept);
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  always #10 clk = ~clk;
  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      conclude();
    end
  end
  // four-state compare so an unknown never passes
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // latched alarms: set in every view, cleared per source only after read and accept
  task automatic t_alarm();
    power_restored_event = 1'b1;
    loop_reconfig_event = 1'b1;
    actuator_unavailable_flag[31] = 1'b1;
    field_unit_comm_fail[7] = 1'b1;
    tick(1);
    power_restored_event = 1'b0;
    loop_reconfig_event = 1'b0;
    check(alarm_view, {4{5'h17}});
    i_lsab_host_model.pulse(0, 1'b1);
    tick(1);
    check(alarm_view[4:0], 5'h17);
    i_lsab_host_model.set_addr(1, 8'h05);
    tick(1);
    check(source_addr_hit, 4'hd);
    i_lsab_host_model.pulse(1, 1'b0);
    i_lsab_host_model.set_addr(1, 8'h04);
    i_lsab_host_model.pulse(0, 1'b0);
    i_lsab_host_model.pulse(0, 1'b1);
    i_lsab_host_model.pulse(1, 1'b1);
    tick(1);
    check(source_addr_hit, 4'hf);
    check(alarm_view, {{3{5'h17}}, 5'h06});
    actuator_unavailable_flag[31] = 1'b0;
    field_unit_comm_fail[7] = 1'b0;
    field_unit_alarm[0] = 1'b1;
    i_lsab_host_model.pulse(0, 1'b0);
    i_lsab_host_model.pulse(0, 1'b1);
    tick(1);
    check(alarm_view[4:0], 5'h04);
  endtask
  // back-to-back position frames across both encodings and the ends of the range
  task automatic t_pos();
    logic [6:0] pct [3] = '{7'd50, 7'd100, 7'd0};
    logic [15:0] exp;
    pos_request = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      pos_percent = pct[i/2];
      pos_variant_pct = i[0];
      exp = i[0] ? 16'(pct[i/2]) : 16'(32'(pct[i/2]) * 32'h7ffe / 32'd100);
      tick(1);
      check({pos_valid, pos_func, pos_addr, pos_data}, {1'b1, 8'h06, 16'h0019, exp});
    end
    pos_request = 1'b0;
    tick(1);
    check(pos_valid, 1'b0);
  endtask
  // loop levels and the synchronised shutdown contact
  task automatic t_levels();
    loopback_active = 1'b1;
    loop_doubling_request = 1'b1;
    loop_reconfig_busy = 1'b1;
    tick(1);
    check({loopback_in_use, loop_doubling_available, loopback_in_progress}, 3'h5);
    loopback_active = 1'b0;
    loop_reconfig_busy = 1'b0;
    tick(1);
    check({loopback_in_use, loop_doubling_available, loopback_in_progress}, 3'h2);
    // enable low must freeze the status flops although the input moves
    clk_en = 1'b0;
    loopback_active = 1'b1;
    tick(1);
    check({loopback_in_use, loop_doubling_available}, 2'h1);
    clk_en = 1'b1;
    tick(1);
    check({loopback_in_use, loop_doubling_available}, 2'h2);
    loopback_active = 1'b0;
    remote_shutdown_enable = 1'b1;
    emergency_shutdown_input = 1'b0;
    tick(2);
    check(emergency_shutdown_mode, 1'b0);
    tick(1);
    check(emergency_shutdown_mode, 1'b1);
    remote_shutdown_enable = 1'b0;
    tick(1);
    check(emergency_shutdown_mode, 1'b0);
  endtask
  // every combination of answering side, loop owner and which single side is healthy, then pair config off
  task automatic t_standby();
    standby_pair_config = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      standby_pair_config = (i < 8);
      answering_side_b = i[0];
      loop_owner_side_b = i[1];
      side_a_healthy = i[2] | i[3];
      side_b_healthy = ~i[2];
      tick(1);
      if (i < 8)
        check({side_indicator, control_owner, side_a_ok, side_b_ok},
          {i[0], i[0] == i[1], i[2], ~i[2]});
      else
        check({side_indicator, control_owner, side_a_ok, side_b_ok}, 4'h0);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    tick(2);
    reset = 1'b0;
    check({alarm_view, pos_valid, emergency_shutdown_mode, loopback_in_use}, '0);
    t_alarm();
    t_pos();
    t_levels();
    t_standby();
    conclude();
  end
endmodule
